// >>> video_fmt_pkg.sv
/*
 * Shared constants and types for the video format, framing and test
 * pattern control block.
 * Assumes an 8-bit register port and a 20-bit deserialized word stream.
 */
`default_nettype none
package video_fmt_pkg;

   // Register offsets (printed offsets used directly on the plain port)
   localparam logic [7:0] FORMAT_FORCE_CONTROL_OFF = 8'h0b;
   localparam logic [7:0] FORMAT_DETECT_STATUS_OFF = 8'h0c;
   localparam logic [7:0] TEST_PATTERN_CONTROL_OFF = 8'h0d;
   localparam logic [7:0] FRAMING_CONTROL_OFF = 8'h10;

   // Field positions
   localparam int FMT_HD_BIT = 4;
   localparam int FMT_PAL_BIT = 3;
   localparam int HIGH_DEF_LOCK_ONLY_BIT = 5;
   localparam int STD_DEF_LOCK_ONLY_BIT = 6;
   localparam int FRAME_MODE_BIT = 7;
   localparam int PAT_HD_BIT = 5;
   localparam int PAT_PROG_BIT = 4;
   localparam int PAT_GEN_ON_BIT = 6;
   localparam int PASS_BIT = 7;
   localparam int TRS_H_BIT = 6;
   localparam int TRS_V_BIT = 7;
   localparam int TRS_F_BIT = 8;

   // Reset values
   localparam logic [7:0] FORCE_RESET = 8'h80;
   localparam logic [7:0] TEST_RESET = 8'h00;
   localparam logic [4:0] FMT_NONE = 5'h00;

   // Format codes
   localparam logic [4:0] FMT_525_54 = 5'h01;
   localparam logic [4:0] FMT_525_36 = 5'h02;
   localparam logic [4:0] FMT_525_27 = 5'h03;
   localparam logic [4:0] FMT_625_54 = 5'h09;
   localparam logic [4:0] FMT_625_36 = 5'h0a;
   localparam logic [4:0] FMT_625_27 = 5'h0b;
   localparam logic [4:0] FMT_260_30I = 5'h11;
   localparam logic [4:0] FMT_274_30I = 5'h12;
   localparam logic [4:0] FMT_274_30P = 5'h13;
   localparam logic [4:0] FMT_274_25I = 5'h19;
   localparam logic [4:0] FMT_274_25P = 5'h1a;
   localparam logic [4:0] FMT_295_25I = 5'h1c;
   localparam logic [4:0] FMT_274_24P = 5'h1d;
   localparam logic [4:0] FMT_296_60P = 5'h14;

   // Raster totals: samples per line, lines per frame and active lines
   localparam logic [11:0] SMP_525_54 = 12'hd68;
   localparam logic [11:0] SMP_525_36 = 12'h8f0;
   localparam logic [11:0] SMP_525_27 = 12'h6b4;
   localparam logic [11:0] SMP_625_54 = 12'hd80;
   localparam logic [11:0] SMP_625_36 = 12'h900;
   localparam logic [11:0] SMP_625_27 = 12'h6c0;
   localparam logic [11:0] SMP_2200 = 12'h898;
   localparam logic [11:0] SMP_2640 = 12'ha50;
   localparam logic [11:0] SMP_2376 = 12'h948;
   localparam logic [11:0] SMP_2750 = 12'habe;
   localparam logic [11:0] SMP_1650 = 12'h672;
   localparam logic [10:0] LN_525 = 11'h20d;
   localparam logic [10:0] LN_625 = 11'h271;
   localparam logic [10:0] LN_1125 = 11'h465;
   localparam logic [10:0] LN_1250 = 11'h4e2;
   localparam logic [10:0] LN_750 = 11'h2ee;
   localparam logic [10:0] ACT_1035 = 11'h40b;

   // Pattern type field (bits 1:0)
   localparam logic [1:0] PAT_BLACK = 2'h0;
   localparam logic [1:0] PAT_PLL = 2'h1;
   localparam logic [1:0] PAT_EQ = 2'h2;
   localparam logic [1:0] PAT_BARS = 2'h3;
   localparam logic [5:0] PAT_SD_NTSC_BARS = 6'h03;
   localparam logic [5:0] PAT_SD_PAL_PLL = 6'h11;

   // Acquisition range driven to the clock recovery
   typedef enum logic [1:0] {
      RANGE_BOTH = 2'h0,
      RANGE_HD = 2'h1,
      RANGE_SD = 2'h2
   } range_t;

   // Timing reference found by the word search
   typedef struct packed {
      logic valid;
      logic [4:0] offset;
      logic [9:0] xyz;
   } trs_t;

   // Raster measurement of the incoming stream
   typedef struct packed {
      logic valid;
      logic progressive;
      logic [11:0] samples;
      logic [10:0] lines;
      logic [10:0] active;
   } meas_t;

   // Self-test progress from the pattern checker
   typedef struct packed {
      logic frame_done;
      logic mismatch;
   } built_in_self_test_t;

endpackage
`default_nettype wire

// >>> video_fmt_ctrl.sv
/*
 * Format force/detect, word framing and test pattern control.
 * Assumes the TRS search, raster measurement and pattern checker run on
 * ref_clk_i; only the realign pin and the reset release come from outside and are synchronised.
 */
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - forced code restricts receiver to one format
// - code bit 4 set means HD
// - code bit 3 PAL, 24P HD also one
// - codes follow the raster table
// - High_def_lock_only limits acquisition and detection to HD
// - Std_def_lock_only limits acquisition and detection to SD
// - both clear searches SD and HD
// - default framing locks on first TRS
// - off-boundary TRS flags until aligned TRS
// - mode bit realigns while flag asserted
// - realign-every bit realigns on each TRS
// - alignment-style bit resets to one
// - detected format stored as five-bit code
// - detected bit 4 HD, bit 3 PAL
// - 74.25 and 74.25/1.001 report same code
// - H, V, F copy TRS bits 6-8
// - H, V, F held until next taken TRS
// - pattern choice selects generator/self-test data
// - generator enable also starts self-test
// - self-test result reads one on pass
// - pattern word: HD, prog/PAL, type bits
module video_fmt_ctrl (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic clk_en_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire video_fmt_pkg::trs_t trs_i,
   input wire video_fmt_pkg::meas_t meas_i,
   input wire video_fmt_pkg::built_in_self_test_t built_in_self_test_i,
   input wire logic realign_input_i,
   output logic misaligned_trs_flag_o,
   output logic [4:0] word_offset_o,
   output logic framer_locked_o,
   output video_fmt_pkg::range_t search_range_o,
   output logic [4:0] detected_format_o,
   output logic [2:0] hvf_o,
   output logic [5:0] pattern_sel_o,
   output logic pattern_gen_on_o,
   output logic built_in_self_test_on_o
);
   import video_fmt_pkg::*;

   // Framer states
   typedef enum logic {
      FR_SEARCH,
      FR_LOCKED
   } frame_state_t;

   // Raster lookup; rate is never an input, so /1.001 rates match too
   function automatic logic [4:0] raster_code(input meas_t m);
      logic [4:0] c;
      c = FMT_NONE;
      case (m.samples)
         SMP_525_54: c = FMT_525_54;
         SMP_525_36: c = FMT_525_36;
         SMP_525_27: c = FMT_525_27;
         SMP_625_54: c = FMT_625_54;
         SMP_625_36: c = FMT_625_36;
         SMP_625_27: c = FMT_625_27;
         SMP_2200: begin
            if (m.progressive) begin
               c = FMT_274_30P;
            end else if (m.active == ACT_1035) begin
               c = FMT_260_30I;
            end else begin
               c = FMT_274_30I;
            end
         end
         SMP_2640: c = m.progressive ? FMT_274_25P : FMT_274_25I;
         SMP_2376: c = FMT_295_25I;
         SMP_2750: c = FMT_274_24P;
         SMP_1650: c = FMT_296_60P;
         default: c = FMT_NONE;
      endcase
      return c;
   endfunction

   // Expected line count per code, used to reject half-matches
   function automatic logic [10:0] code_lines(input logic [4:0] c);
      logic [10:0] l;
      l = LN_1125;
      if (!c[FMT_HD_BIT]) begin
         l = c[FMT_PAL_BIT] ? LN_625 : LN_525;
      end else if (c == FMT_295_25I) begin
         l = LN_1250;
      end else if (c == FMT_296_60P) begin
         l = LN_750;
      end
      return l;
   endfunction

   // Patterns that double as self-test data
   function automatic logic is_built_in_self_test_pat(input logic [5:0] p);
      return (p[PAT_HD_BIT] && p[1:0] == PAT_BARS) ||
         p == PAT_SD_NTSC_BARS || p == PAT_SD_PAL_PLL;
   endfunction

   // Reset synchroniser and realign pin synchroniser
   logic [1:0] rst_sync_r;
   logic rst_n;
   logic realign_meta_r;
   logic realign_pin_r;

   // Registers
   logic [7:0] force_ctrl_r;
   logic [5:0] pattern_sel_r;
   logic pattern_gen_on_r;
   logic realign_every_r;
   logic [7:0] rdata_r;

   // Framer state
   frame_state_t frame_state_r;
   frame_state_t frame_state_nxt;
   logic [4:0] offset_r;
   logic [4:0] offset_nxt;
   logic misaligned_r;
   logic misaligned_nxt;
   logic [2:0] hvf_r;

   // Detection and self-test state
   logic [4:0] detected_r;
   range_t range_r;
   logic built_in_self_test_run_r;
   logic built_in_self_test_seen_r;
   logic built_in_self_test_fail_r;
   logic built_in_self_test_pass_r;

   assign rst_n = rst_sync_r[1];

   // Two-stage reset release
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end

   // Realign pin is asynchronous to the word clock
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         realign_meta_r <= 1'b0;
         realign_pin_r <= 1'b0;
      end else if (clk_en_i) begin
         realign_meta_r <= realign_input_i;
         realign_pin_r <= realign_meta_r;
      end
   end

   // Register decode
   wire wr_force = reg_wr_i && reg_addr_i == FORMAT_FORCE_CONTROL_OFF;
   wire wr_test = reg_wr_i && reg_addr_i == TEST_PATTERN_CONTROL_OFF;
   wire wr_frame = reg_wr_i && reg_addr_i == FRAMING_CONTROL_OFF;
   wire [4:0] force_code = force_ctrl_r[4:0];
   wire high_def_lock_only = force_ctrl_r[HIGH_DEF_LOCK_ONLY_BIT];
   wire std_def_lock_only = force_ctrl_r[STD_DEF_LOCK_ONLY_BIT];
   wire frame_mode = force_ctrl_r[FRAME_MODE_BIT];
   wire realign_every = realign_every_r || realign_pin_r;

   // Control registers; detect status has no write path
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         force_ctrl_r <= FORCE_RESET;
         pattern_sel_r <= TEST_RESET[5:0];
         pattern_gen_on_r <= 1'b0;
         realign_every_r <= 1'b0;
      end else if (clk_en_i) begin
         if (wr_force) begin
            force_ctrl_r <= reg_wdata_i;
         end
         if (wr_test) begin
            pattern_sel_r <= reg_wdata_i[5:0];
            pattern_gen_on_r <= reg_wdata_i[PAT_GEN_ON_BIT];
         end
         if (wr_frame) begin
            realign_every_r <= reg_wdata_i[0];
         end
      end
   end

   // Read mux; unmapped addresses read zero
   wire [7:0] rd_force = force_ctrl_r;
   wire [7:0] rd_detect = {hvf_r, detected_r};
   wire [7:0] rd_test = {built_in_self_test_pass_r, pattern_gen_on_r, pattern_sel_r};
   wire [7:0] rd_frame = {6'h00, misaligned_r, realign_every_r};
   wire [7:0] rd_mux =
      reg_addr_i == FORMAT_FORCE_CONTROL_OFF ? rd_force :
      reg_addr_i == FORMAT_DETECT_STATUS_OFF ? rd_detect :
      reg_addr_i == TEST_PATTERN_CONTROL_OFF ? rd_test :
      reg_addr_i == FRAMING_CONTROL_OFF ? rd_frame : 8'h00;

   // Read data stand for one cycle only
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= 8'h00;
      end else if (clk_en_i) begin
         rdata_r <= reg_rd_i ? rd_mux : 8'h00;
      end
   end

   // Framer next-state logic
   wire on_boundary = trs_i.offset == offset_r;
   wire realign_now = realign_every || (frame_mode && misaligned_r);
   always_comb begin
      frame_state_nxt = frame_state_r;
      offset_nxt = offset_r;
      misaligned_nxt = misaligned_r;
      case (frame_state_r)
         FR_SEARCH: begin
            if (trs_i.valid) begin
               frame_state_nxt = FR_LOCKED;
               offset_nxt = trs_i.offset;
               misaligned_nxt = 1'b0;
            end
         end
         FR_LOCKED: begin
            if (trs_i.valid) begin
               if (on_boundary) begin
                  misaligned_nxt = 1'b0;
               end else if (realign_now) begin
                  // Looped flag realigns on the next TRS after it rose
                  offset_nxt = trs_i.offset;
                  misaligned_nxt = 1'b0;
               end else begin
                  misaligned_nxt = 1'b1;
               end
            end
         end
         default: begin
            frame_state_nxt = FR_SEARCH;
         end
      endcase
   end

   // Framer state, timing bits from each taken TRS: the first one, one on the boundary, or one that realigns
   wire trs_taken = trs_i.valid &&
      (frame_state_r == FR_SEARCH || on_boundary || realign_now);
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         frame_state_r <= FR_SEARCH;
         offset_r <= 5'h00;
         misaligned_r <= 1'b0;
         hvf_r <= 3'h0;
      end else if (clk_en_i) begin
         frame_state_r <= frame_state_nxt;
         offset_r <= offset_nxt;
         misaligned_r <= misaligned_nxt;
         if (trs_taken) begin
            // Held until the next taken TRS, so F spans its field
            hvf_r <= {trs_i.xyz[TRS_F_BIT], trs_i.xyz[TRS_V_BIT],
               trs_i.xyz[TRS_H_BIT]};
         end
      end
   end

   // Detection filter: range and forced code both gate a match
   wire [4:0] meas_code = raster_code(meas_i);
   wire lines_ok = meas_i.lines == code_lines(meas_code);
   wire in_range = !(high_def_lock_only && !meas_code[FMT_HD_BIT]) &&
      !(std_def_lock_only && meas_code[FMT_HD_BIT]);
   wire force_ok = force_code == FMT_NONE || meas_code == force_code;
   wire accept = meas_i.valid && meas_code != FMT_NONE && lines_ok &&
      in_range && force_ok;
   wire range_t range_sel = high_def_lock_only ? RANGE_HD :
      std_def_lock_only ? RANGE_SD : RANGE_BOTH;

   // Detected code, unknown rasters clear it
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         detected_r <= FMT_NONE;
         range_r <= RANGE_BOTH;
      end else if (clk_en_i) begin
         range_r <= range_sel;
         if (wr_force) begin
            // New forced code or range voids the old result
            detected_r <= FMT_NONE;
         end else if (meas_i.valid) begin
            detected_r <= accept ? meas_code : FMT_NONE;
         end
      end
   end

   // Self-test: runs with the generator, passes after a clean frame of a self-test pattern
   wire built_in_self_test_ok_pat = is_built_in_self_test_pat(pattern_sel_r);
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         built_in_self_test_run_r <= 1'b0;
         built_in_self_test_seen_r <= 1'b0;
         built_in_self_test_fail_r <= 1'b0;
         built_in_self_test_pass_r <= 1'b0;
      end else if (clk_en_i) begin
         built_in_self_test_run_r <= pattern_gen_on_r;
         if (pattern_gen_on_r && !built_in_self_test_run_r) begin
            // Fresh run forgets the previous outcome
            built_in_self_test_seen_r <= 1'b0;
            built_in_self_test_fail_r <= 1'b0;
            built_in_self_test_pass_r <= 1'b0;
         end else if (built_in_self_test_run_r) begin
            if (built_in_self_test_i.frame_done) begin
               built_in_self_test_seen_r <= 1'b1;
            end
            if (built_in_self_test_i.mismatch) begin
               built_in_self_test_fail_r <= 1'b1;
            end
            built_in_self_test_pass_r <= built_in_self_test_ok_pat && built_in_self_test_seen_r &&
               !built_in_self_test_fail_r && !built_in_self_test_i.mismatch;
         end
      end
   end

   // Outputs straight from flops
   assign reg_rdata_o = rdata_r;
   assign misaligned_trs_flag_o = misaligned_r;
   assign word_offset_o = offset_r;
   assign framer_locked_o = frame_state_r == FR_LOCKED;
   assign search_range_o = range_r;
   assign detected_format_o = detected_r;
   assign hvf_o = hvf_r;
   assign pattern_sel_o = pattern_sel_r;
   assign pattern_gen_on_o = pattern_gen_on_r;
   assign built_in_self_test_on_o = built_in_self_test_run_r;

   // Assertions
   sequence off_trs_s;
      clk_en_i && trs_i.valid && frame_state_r == FR_LOCKED &&
         !on_boundary;
   endsequence
   sequence on_trs_s;
      clk_en_i && trs_i.valid && frame_state_r == FR_LOCKED && on_boundary;
   endsequence

   flag_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      off_trs_s and (!realign_now) |=> misaligned_r)
      else $error("misalignment flag not set");
   flag_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      on_trs_s |=> !misaligned_r)
      else $error("misalignment flag not cleared");
   every_align_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      off_trs_s and (realign_every) |=>
      offset_r == $past(trs_i.offset) && !misaligned_r)
      else $error("realign on every TRS failed");
   mode_loop_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      off_trs_s and (frame_mode && misaligned_r) |=>
      offset_r == $past(trs_i.offset) && !misaligned_r)
      else $error("looped realign failed");
   first_lock_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      clk_en_i && trs_i.valid && frame_state_r == FR_SEARCH |=>
      framer_locked_o && offset_r == $past(trs_i.offset))
      else $error("first TRS lock failed");
   force_only_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      force_code != FMT_NONE && detected_r != FMT_NONE |->
      detected_r == force_code || $changed(force_code))
      else $error("detected code differs from forced code");
   hd_range_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      clk_en_i && meas_i.valid && high_def_lock_only |=>
      detected_r == FMT_NONE || detected_r[FMT_HD_BIT])
      else $error("SD code detected in High_def_lock_only mode");
   sd_range_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      clk_en_i && meas_i.valid && std_def_lock_only |=> !detected_r[FMT_HD_BIT])
      else $error("HD code detected in Std_def_lock_only mode");
   hvf_copy_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      on_trs_s |=> hvf_r == {$past(trs_i.xyz[TRS_F_BIT]),
      $past(trs_i.xyz[TRS_V_BIT]), $past(trs_i.xyz[TRS_H_BIT])})
      else $error("timing bits not copied");
   built_in_self_test_start_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
      clk_en_i && $rose(pattern_gen_on_r) |=>
      built_in_self_test_on_o ##0 !built_in_self_test_pass_r)
      else $error("self-test did not start with generator");

endmodule
`default_nettype wire

// >>> video_src_model.sv
/*
 * Far-side model: TRS finder, raster meter and pattern checker pulses,
 * each sent whole on request of the bench.
 * Assumes the word clock of the block; fields go stale after a pulse.
 */
`timescale 1ns/1ns
`default_nettype none
module video_src_model
   import video_fmt_pkg::*;
(
   input wire logic clk_i,
   output video_fmt_pkg::trs_t trs_o,
   output video_fmt_pkg::meas_t meas_o,
   output video_fmt_pkg::built_in_self_test_t built_in_self_test_o
);
   // Idle at time zero
   initial begin
      trs_o = '0;
      meas_o = '0;
      built_in_self_test_o = '0;
   end

   // One TRS pulse; fields flip after it so nothing leans on stale data
   task automatic send_trs(input logic [4:0] off, input logic [9:0] xyz);
      @(posedge clk_i);
      trs_o <= '{valid: 1'b1, offset: off, xyz: xyz};
      @(posedge clk_i);
      trs_o <= '{valid: 1'b0, offset: ~off, xyz: ~xyz};
   endtask

   // One raster measurement pulse
   task automatic send_meas(input logic prog, input logic [11:0] smp,
                            input logic [10:0] ln, input logic [10:0] act);
      @(posedge clk_i);
      meas_o <= '{1'b1, prog, smp, ln, act};
      @(posedge clk_i);
      meas_o <= '{1'b0, ~prog, ~smp, ~ln, ~act};
   endtask

   // End of a checked frame, with or without a pattern mismatch
   task automatic send_frame(input logic mm);
      @(posedge clk_i);
      built_in_self_test_o <= '{frame_done: 1'b1, mismatch: mm};
      @(posedge clk_i);
      built_in_self_test_o <= '0;
   endtask
endmodule
`default_nettype wire

// >>> tb_video_format_framing_test_ctrl.sv
/*
 * Self-checking bench for the format, framing and test pattern block.
 * Assumes the far-side model above and a 100 MHz word clock.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_video_format_framing_test_ctrl;
   import video_fmt_pkg::*;
   logic clk = 1'b0;
   logic arst_n, clk_en, reg_wr_s, reg_rd_s, realign, flag, locked;
   logic gen_on, built_in_self_test_on;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [4:0] offset, detected;
   logic [2:0] hvf;
   logic [5:0] pattern_sel;
   range_t range;
   trs_t trs;
   meas_t meas;
   built_in_self_test_t built_in_self_test;
   int error_cnt = 0;
   int checks = 0;
   // Raster table: code, samples, lines, active lines, progressive
   logic [4:0] codes [14] = '{FMT_525_54, FMT_525_36, FMT_525_27,
      FMT_625_54, FMT_625_36, FMT_625_27, FMT_260_30I, FMT_274_30I,
      FMT_274_30P, FMT_274_25I, FMT_274_25P, FMT_295_25I, FMT_274_24P,
      FMT_296_60P};
   logic [11:0] smps [14] = '{SMP_525_54, SMP_525_36, SMP_525_27,
      SMP_625_54, SMP_625_36, SMP_625_27, SMP_2200, SMP_2200, SMP_2200,
      SMP_2640, SMP_2640, SMP_2376, SMP_2750, SMP_1650};
   logic [10:0] lns [14] = '{LN_525, LN_525, LN_525, LN_625, LN_625,
      LN_625, LN_1125, LN_1125, LN_1125, LN_1125, LN_1125, LN_1250,
      LN_1125, LN_750};
   logic [10:0] acts [14] = '{11'h1fb, 11'h1fb, 11'h1fb, 11'h241,
      11'h241, 11'h241, ACT_1035, 11'h438, 11'h438, 11'h438, 11'h438,
      11'h438, 11'h438, 11'h2d0};
   logic [13:0] progs = 14'h3500;

   // Free-running word clock
   always #5 clk = ~clk;

   video_src_model src (.clk_i(clk), .trs_o(trs), .meas_o(meas),
      .built_in_self_test_o(built_in_self_test));

   video_fmt_ctrl dut (.ref_clk_i(clk), .arst_n_i(arst_n),
      .clk_en_i(clk_en), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .reg_wr_i(reg_wr_s), .reg_rd_i(reg_rd_s), .reg_rdata_o(reg_rdata),
      .trs_i(trs), .meas_i(meas), .built_in_self_test_i(built_in_self_test),
      .realign_input_i(realign), .misaligned_trs_flag_o(flag),
      .word_offset_o(offset), .framer_locked_o(locked),
      .search_range_o(range), .detected_format_o(detected),
      .hvf_o(hvf), .pattern_sel_o(pattern_sel),
      .pattern_gen_on_o(gen_on), .built_in_self_test_on_o(built_in_self_test_on));

   // Verdict and end of run, also reached from a timeout
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Register read-back comparison
   task automatic chk_reg(input string nm, input logic [7:0] exp,
                          input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Output pin comparison, zero-extended to a byte
   task automatic chk_out(input string nm, input logic [7:0] exp,
                          input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One-cycle write strobe
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr_s <= 1'b1;
      @(posedge clk);
      reg_wr_s <= 1'b0;
   endtask

   // One-cycle read strobe; data only stand in the following cycle
   task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp,
                          input string nm);
      @(posedge clk);
      reg_addr <= a;
      reg_rd_s <= 1'b1;
      @(posedge clk);
      reg_rd_s <= 1'b0;
      #1 chk_reg(nm, exp, reg_rdata);
   endtask

   // Measurement then check of the detected code
   task automatic meas_chk(input int i, input logic [4:0] exp);
      src.send_meas(progs[i], smps[i], lns[i], acts[i]);
      #1 chk_out("detected", {3'h0, exp}, {3'h0, detected});
   endtask

   task automatic t_reset();
      reg_chk(FORMAT_FORCE_CONTROL_OFF, FORCE_RESET, "force");
      reg_chk(FORMAT_DETECT_STATUS_OFF, 8'h00, "detect");
      reg_chk(TEST_PATTERN_CONTROL_OFF, TEST_RESET, "test");
      chk_out("locked", 8'h00, {7'h0, locked});
      reg_chk(8'h20, 8'h00, "unmapped");
      chk_out("range", {6'h0, RANGE_BOTH}, {6'h0, range});
      $display("test reset done");
   endtask

   // Every raster, then the range and forced restrictions
   task automatic t_detect();
      for (int i = 0; i < 14; i++) begin
         meas_chk(i, codes[i]);
         chk_out("hd", {7'h0, i > 5}, {7'h0, detected[FMT_HD_BIT]});
         chk_out("pal", {7'h0, (i > 2 && i < 6) || (i > 8 && i < 13)},
            {7'h0, detected[FMT_PAL_BIT]});
      end
      reg_wr(FORMAT_DETECT_STATUS_OFF, 8'hff);
      reg_chk(FORMAT_DETECT_STATUS_OFF, {3'h0, FMT_296_60P}, "ro");
      reg_wr(FORMAT_FORCE_CONTROL_OFF, 8'h20);
      meas_chk(2, FMT_NONE);
      meas_chk(7, FMT_274_30I);
      chk_out("range", {6'h0, RANGE_HD}, {6'h0, range});
      reg_wr(FORMAT_FORCE_CONTROL_OFF, 8'h40);
      meas_chk(7, FMT_NONE);
      meas_chk(5, FMT_625_27);
      chk_out("range", {6'h0, RANGE_SD}, {6'h0, range});
      reg_wr(FORMAT_FORCE_CONTROL_OFF, {3'h0, FMT_525_27});
      meas_chk(5, FMT_NONE);
      meas_chk(0, FMT_NONE);
      meas_chk(2, FMT_525_27);
      reg_wr(FORMAT_FORCE_CONTROL_OFF, {3'h0, FMT_274_30P});
      meas_chk(7, FMT_NONE);
      reg_wr(FORMAT_FORCE_CONTROL_OFF, 8'h00);
      meas_chk(2, FMT_525_27);
      chk_out("range", {6'h0, RANGE_BOTH}, {6'h0, range});
      $display("test detect done");
   endtask

   // TRS then check of boundary, flag and H/V/F
   task automatic trs_chk(input logic [4:0] off, input logic [9:0] xyz,
         input logic [4:0] e_off, input logic e_flag, input logic [2:0] e_hvf);
      src.send_trs(off, xyz);
      #1 chk_out("offset", {3'h0, e_off}, {3'h0, offset});
      chk_out("flag", {7'h0, e_flag}, {7'h0, flag});
      chk_out("hvf", {5'h0, e_hvf}, {5'h0, hvf});
   endtask

   task automatic t_framing();
      trs_chk(5'd3, 10'h2c0, 5'd3, 1'b0, 3'b011);
      chk_out("locked", 8'h01, {7'h0, locked});
      trs_chk(5'd5, 10'h340, 5'd3, 1'b1, 3'b011);
      trs_chk(5'd5, 10'h340, 5'd3, 1'b1, 3'b011);
      trs_chk(5'd3, 10'h340, 5'd3, 1'b0, 3'b101);
      reg_chk(FORMAT_DETECT_STATUS_OFF, {3'b101, FMT_525_27}, "hvf");
      reg_wr(FRAMING_CONTROL_OFF, 8'h01);
      trs_chk(5'd7, 10'h2c0, 5'd7, 1'b0, 3'b011);
      reg_chk(FRAMING_CONTROL_OFF, 8'h01, "framing");
      reg_wr(FRAMING_CONTROL_OFF, 8'h00);
      reg_wr(FORMAT_FORCE_CONTROL_OFF, 8'h80);
      trs_chk(5'd9, 10'h2c0, 5'd7, 1'b1, 3'b011);
      reg_chk(FRAMING_CONTROL_OFF, 8'h02, "framing");
      trs_chk(5'd9, 10'h340, 5'd9, 1'b0, 3'b101);
      // External loop-back: pin passes a two-flop synchroniser first
      reg_wr(FORMAT_FORCE_CONTROL_OFF, 8'h00);
      realign <= 1'b1;
      repeat (3) @(posedge clk);
      trs_chk(5'd2, 10'h2c0, 5'd2, 1'b0, 3'b011);
      realign <= 1'b0;
      $display("test framing done");
   endtask

   // Pattern run; only documented self-test patterns may pass
   task automatic run_built_in_self_test(input logic [5:0] pat, input logic mm);
      int n;
      logic ok;
      ok = !mm && (pat[5] ? pat[1:0] == PAT_BARS :
         (pat == PAT_SD_NTSC_BARS || pat == PAT_SD_PAL_PLL));
      reg_wr(TEST_PATTERN_CONTROL_OFF, 8'h00);
      reg_wr(TEST_PATTERN_CONTROL_OFF, {2'b11, pat});
      #1 chk_out("pattern", {2'h0, pat}, {2'h0, pattern_sel});
      chk_out("gen_on", 8'h01, {7'h0, gen_on});
      n = 0;
      while (built_in_self_test_on !== 1'b1 && n < 8) begin
         @(posedge clk);
         #1 n++;
      end
      chk_out("built_in_self_test_on", 8'h01, {7'h0, built_in_self_test_on});
      if (n == 8) begin
         stop_test();
      end
      src.send_frame(mm);
      repeat (3) @(posedge clk);
      reg_chk(TEST_PATTERN_CONTROL_OFF, {ok, 1'b1, pat}, "pass");
   endtask

   task automatic t_built_in_self_test();
      run_built_in_self_test(PAT_SD_NTSC_BARS, 1'b0);
      run_built_in_self_test(PAT_SD_PAL_PLL, 1'b0);
      run_built_in_self_test(6'h23, 1'b0);
      run_built_in_self_test(6'h3f, 1'b0);
      run_built_in_self_test(6'h2e, 1'b0);
      run_built_in_self_test(6'h01, 1'b0);
      run_built_in_self_test(6'h23, 1'b1);
      $display("test built_in_self_test done");
   endtask

   // Clock enable low: a write is not taken
   task automatic t_clk_en();
      reg_wr(TEST_PATTERN_CONTROL_OFF, 8'h00);
      @(posedge clk);
      clk_en <= 1'b0;
      reg_wr(TEST_PATTERN_CONTROL_OFF, 8'h05);
      clk_en <= 1'b1;
      reg_chk(TEST_PATTERN_CONTROL_OFF, 8'h00, "frozen");
      $display("test clk_en done");
   endtask

   // Main sequence
   initial begin
      arst_n = 1'b0;
      clk_en = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr_s = 1'b0;
      reg_rd_s = 1'b0;
      realign = 1'b0;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_detect();
      t_framing();
      t_built_in_self_test();
      // Reset again mid-run; all must come back to defaults
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_clk_en();
      stop_test();
   end
endmodule
`default_nettype wire
